// file: arf_pkg.sv
package arf_pkg;

  // Bus and converter widths
  localparam int ARF_CODE_W = 10;
  localparam int ARF_RES_W = 16;
  localparam int ARF_DIV_W = 5;

  // Register byte offsets
  localparam logic [7:0] ARF_OFS_CTRL = 8'h00;
  localparam logic [7:0] ARF_OFS_ACC_CFG = 8'h04;
  localparam logic [7:0] ARF_OFS_CLK_DIV = 8'h08;
  localparam logic [7:0] ARF_OFS_LT_LOW = 8'h0c;
  localparam logic [7:0] ARF_OFS_LT_HIGH = 8'h10;
  localparam logic [7:0] ARF_OFS_RES_HIGH = 8'h14;
  localparam logic [7:0] ARF_OFS_RES_LOW = 8'h18;
  localparam logic [7:0] ARF_OFS_STATUS = 8'h1c;
  localparam logic [7:0] ARF_OFS_TRIGGER = 8'h20;

  // Field positions
  localparam int ARF_CTRL_EN_BIT = 0;
  localparam int ARF_CTRL_BURST_BIT = 1;
  localparam int ARF_CTRL_JUST_LSB = 2;
  localparam int ARF_STAT_BUSY_BIT = 0;
  localparam int ARF_STAT_LT_BIT = 1;
  localparam int ARF_STAT_CNT_LSB = 2;

  // Reset values
  localparam logic [7:0] ARF_CTRL_RST = 8'h00;
  localparam logic [2:0] ARF_RPT_RST = 3'h0;
  localparam logic [ARF_DIV_W-1:0] ARF_DIV_RST = 5'h1f;
  localparam logic [7:0] ARF_LT_RST = 8'h00;
  localparam logic [15:0] ARF_RES_RST = 16'h0000;

  // Timing: system clock and converter power-up interval
  localparam int ARF_CLK_MHZ = 50;
  localparam int ARF_POWERUP_NS = 1000;
  localparam int ARF_POWERUP_CYC = (ARF_POWERUP_NS * ARF_CLK_MHZ + 999) / 1000;

  typedef enum {ARF_IDLE, ARF_POWER, ARF_START, ARF_WAIT_DONE, ARF_WAIT_TRIG} arf_state_t;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hready;
    logic [31:0] hwdata;
  } arf_ahb_req_t;

  typedef struct packed {
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
  } arf_ahb_rsp_t;

  typedef struct packed {
    logic done_toggle;
    logic [ARF_CODE_W-1:0] code;
  } arf_core_in_t;

  typedef struct packed {
    logic conv_start;
    logic power_on;
    logic conv_clk;
  } arf_core_out_t;

endpackage : arf_pkg

// file: arf_result_format.sv
`timescale 1ns/100ps
module arf_result_format #(
  parameter int CODE_W = arf_pkg::ARF_CODE_W,
  parameter int POWERUP_CYC = arf_pkg::ARF_POWERUP_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Register bus
  input wire arf_pkg::arf_ahb_req_t ahb_in,
  output arf_pkg::arf_ahb_rsp_t ahb_out,
  // Converter core
  input wire arf_pkg::arf_core_in_t core_in,
  output arf_pkg::arf_core_out_t core_out,
  // External trigger and window flag
  input wire logic conv_trigger_in,
  output logic window_lt_out
);
  import arf_pkg::*;

  localparam int ACC_W = CODE_W + 6;
  localparam int PCNT_W = $clog2(POWERUP_CYC + 1);

  // Sample count for a repeat_count code; reserved codes act as 64
  function automatic logic [6:0] rpt_samples(input logic [2:0] code);
    logic [6:0] n;
    n = 7'h01;
    case (code)
      3'h0: n = 7'h01;
      3'h1: n = 7'h04;
      3'h2: n = 7'h08;
      3'h3: n = 7'h10;
      3'h4: n = 7'h20;
      default: n = 7'h40;
    endcase
    return n;
  endfunction : rpt_samples

  // Places a sum or single code in the 16-bit result
  function automatic logic [ARF_RES_W-1:0] fmt_result(input logic [ACC_W-1:0] sum,
                                                     input logic [2:0] just, input logic single);
    logic [ARF_RES_W-1:0] r;
    r = ARF_RES_W'(sum);
    if (single && just[2]) begin
      r = ARF_RES_W'(sum[CODE_W-1:0]) << (ARF_RES_W - CODE_W);
    end
    return r;
  endfunction : fmt_result

  // Software registers
  logic conv_en_r;
  logic burst_en_r;
  logic [2:0] justify_r;
  logic [2:0] repeat_r;
  logic [ARF_DIV_W-1:0] div_r;
  logic [7:0] lt_low_r;
  logic [7:0] lt_high_r;
  logic [ARF_RES_W-1:0] result_r;
  logic lt_flag_r;

  // Bus state
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [31:0] hrdata_r;
  logic ahb_take;
  logic sw_trig;

  // Synchronisers for pins from the analog side and for the external trigger pin
  logic [2:0] done_sync_r;
  logic [CODE_W-1:0] code_s1_r;
  logic [CODE_W-1:0] code_s2_r;
  logic [2:0] trig_sync_r;
  logic done_evt;
  logic pin_trig;

  // Sequencer
  arf_state_t state_r;
  arf_state_t state_nxt;
  logic [ACC_W-1:0] acc_r;
  logic [6:0] cnt_r;
  logic [6:0] target_r;
  logic [PCNT_W-1:0] pwr_cnt_r;
  logic conv_start_r;
  logic power_on_r;
  logic trig;
  logic last;
  logic [ACC_W-1:0] acc_sum;

  // Converter clock divider
  logic [ARF_DIV_W:0] div_cnt_r;
  logic [ARF_DIV_W:0] div_n;
  logic conv_clk_r;

  // Code is held by the core until the next start, so a plain two-stage copy is safe
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      done_sync_r <= 3'h0;
      code_s1_r <= '0;
      code_s2_r <= '0;
      trig_sync_r <= 3'h0;
    end else begin
      done_sync_r <= {done_sync_r[1:0], core_in.done_toggle};
      code_s1_r <= core_in.code;
      code_s2_r <= code_s1_r;
      trig_sync_r <= {trig_sync_r[1:0], conv_trigger_in};
    end
  end

  assign done_evt = done_sync_r[2] ^ done_sync_r[1];
  assign pin_trig = trig_sync_r[1] & ~trig_sync_r[2];

  // Bus address phase
  assign ahb_take = ahb_in.hsel && ahb_in.htrans[1] && ahb_in.hready;
  assign sw_trig = wr_pend_r && (wr_addr_r == ARF_OFS_TRIGGER) && ahb_in.hwdata[0];

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= ahb_take && ahb_in.hwrite;
      wr_addr_r <= ahb_in.haddr[7:0];
    end
  end

  // Configuration writes land in the data phase
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      conv_en_r <= ARF_CTRL_RST[ARF_CTRL_EN_BIT];
      burst_en_r <= ARF_CTRL_RST[ARF_CTRL_BURST_BIT];
      justify_r <= ARF_CTRL_RST[ARF_CTRL_JUST_LSB +: 3];
      repeat_r <= ARF_RPT_RST;
      div_r <= ARF_DIV_RST;
      lt_low_r <= ARF_LT_RST;
      lt_high_r <= ARF_LT_RST;
    end else if (wr_pend_r) begin
      unique case (wr_addr_r)
        ARF_OFS_CTRL: begin
          conv_en_r <= ahb_in.hwdata[ARF_CTRL_EN_BIT];
          burst_en_r <= ahb_in.hwdata[ARF_CTRL_BURST_BIT];
          justify_r <= ahb_in.hwdata[ARF_CTRL_JUST_LSB +: 3];
        end
        ARF_OFS_ACC_CFG: repeat_r <= ahb_in.hwdata[2:0];
        ARF_OFS_CLK_DIV: div_r <= ahb_in.hwdata[ARF_DIV_W-1:0];
        ARF_OFS_LT_LOW: lt_low_r <= ahb_in.hwdata[7:0];
        ARF_OFS_LT_HIGH: lt_high_r <= ahb_in.hwdata[7:0];
        default: begin
        end
      endcase
    end
  end

  // Read data is prepared at the address phase, so the slave never waits
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hrdata_r <= 32'h0000_0000;
    end else if (ahb_take && !ahb_in.hwrite) begin
      unique case (ahb_in.haddr[7:0])
        ARF_OFS_CTRL: hrdata_r <= {27'h0, justify_r, burst_en_r, conv_en_r};
        ARF_OFS_ACC_CFG: hrdata_r <= {29'h0, repeat_r};
        ARF_OFS_CLK_DIV: hrdata_r <= {27'h0, div_r};
        ARF_OFS_LT_LOW: hrdata_r <= {24'h0, lt_low_r};
        ARF_OFS_LT_HIGH: hrdata_r <= {24'h0, lt_high_r};
        ARF_OFS_RES_HIGH: hrdata_r <= {24'h0, result_r[15:8]};
        ARF_OFS_RES_LOW: hrdata_r <= {24'h0, result_r[7:0]};
        ARF_OFS_STATUS: hrdata_r <= {23'h0, cnt_r, lt_flag_r, state_r != ARF_IDLE};
        default: hrdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // Sequencer
  assign trig = sw_trig | pin_trig;
  assign acc_sum = acc_r + ACC_W'(code_s2_r);
  assign last = (cnt_r + 7'h01) == target_r;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ARF_IDLE: begin
        // A core that is not yet warm waits out power-up, even in always-on mode
        if (trig && (conv_en_r || burst_en_r) && (!power_on_r || pwr_cnt_r != '0)) begin
          state_nxt = ARF_POWER;
        end else if (trig && (conv_en_r || burst_en_r)) begin
          state_nxt = ARF_START;
        end
      end
      ARF_POWER: begin
        if (pwr_cnt_r == '0) begin
          state_nxt = ARF_START;
        end
      end
      ARF_START: state_nxt = ARF_WAIT_DONE;
      ARF_WAIT_DONE: begin
        if (done_evt && last) begin
          state_nxt = ARF_IDLE;
        end else if (done_evt && burst_en_r) begin
          state_nxt = ARF_START;
        end else if (done_evt) begin
          state_nxt = ARF_WAIT_TRIG;
        end
      end
      ARF_WAIT_TRIG: begin
        if (trig) begin
          state_nxt = ARF_START;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r <= ARF_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Power-up time counts from power-on, so samples inside a burst never wait again
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pwr_cnt_r <= '0;
    end else if (!power_on_r) begin
      pwr_cnt_r <= PCNT_W'(POWERUP_CYC - 1);
    end else if (pwr_cnt_r != '0) begin
      pwr_cnt_r <= pwr_cnt_r - PCNT_W'(1);
    end
  end

  // Pure burst powers the core only for the burst; always-on keeps it up
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      power_on_r <= 1'b0;
      conv_start_r <= 1'b0;
    end else begin
      power_on_r <= conv_en_r || (state_nxt != ARF_IDLE);
      conv_start_r <= (state_nxt == ARF_START);
    end
  end

  // Series count is latched at the trigger so a mid-series write cannot split it
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      acc_r <= '0;
      cnt_r <= 7'h00;
      target_r <= 7'h01;
    end else if (state_r == ARF_IDLE && state_nxt != ARF_IDLE) begin
      acc_r <= '0;
      cnt_r <= 7'h00;
      target_r <= rpt_samples(repeat_r);
    end else if (state_r == ARF_WAIT_DONE && done_evt) begin
      acc_r <= acc_sum;
      cnt_r <= cnt_r + 7'h01;
    end
  end

  // Result bytes change only when the series ends
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      result_r <= ARF_RES_RST;
      lt_flag_r <= 1'b0;
    end else if (state_r == ARF_WAIT_DONE && done_evt && last) begin
      // Left justification only honoured for single samples; sums stay right-justified
      result_r <= fmt_result(acc_sum, justify_r, target_r == 7'h01);
      lt_flag_r <= fmt_result(acc_sum, justify_r, target_r == 7'h01) < {lt_high_r, lt_low_r};
    end
  end

  // Divider: period is field plus one source clocks; zero acts as one
  assign div_n = (div_r == '0) ? (ARF_DIV_W+1)'(1) : {1'b0, div_r};

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      div_cnt_r <= '0;
      conv_clk_r <= 1'b0;
    end else begin
      div_cnt_r <= (div_cnt_r >= div_n) ? '0 : div_cnt_r + (ARF_DIV_W+1)'(1);
      conv_clk_r <= div_cnt_r < ((div_n + (ARF_DIV_W+1)'(1)) >> 1);
    end
  end

  // Outputs
  assign ahb_out.hreadyout = 1'b1;
  assign ahb_out.hresp = 1'b0;
  assign ahb_out.hrdata = hrdata_r;
  assign core_out.conv_start = conv_start_r;
  assign core_out.power_on = power_on_r;
  assign core_out.conv_clk = conv_clk_r;
  assign window_lt_out = lt_flag_r;

endmodule : arf_result_format

// file: arf_core_model.sv
`timescale 1ns/100ps
module arf_core_model (
  // Clock
  input wire logic clk_in,
  // Requests from the block
  input wire arf_pkg::arf_core_out_t core_in,
  // Test controls
  input wire logic [9:0] code_in,
  input wire logic [3:0] lat_in,
  // Results to the block
  output arf_pkg::arf_core_in_t core_out
);
  import arf_pkg::*;
  logic [3:0] cnt_r;
  logic busy_r;
  initial begin
    core_out = '0;
    cnt_r = 4'h0;
    busy_r = 1'b0;
  end
  // Code is scrambled while converting, so a stale read cannot pass
  always @(posedge clk_in) begin
    if (core_in.conv_start && core_in.power_on) begin
      busy_r <= 1'b1;
      cnt_r <= lat_in;
      core_out.code <= ~core_out.code;
    end else if (busy_r && cnt_r == 4'h0) begin
      busy_r <= 1'b0;
      core_out.code <= code_in;
      core_out.done_toggle <= ~core_out.done_toggle;
    end else if (busy_r) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end
endmodule : arf_core_model

// file: arf_result_format_asserts.sv
`timescale 1ns/100ps
module arf_result_format_asserts
  import arf_pkg::*;
(
  // Watched ports
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire arf_pkg::arf_ahb_req_t ahb_in,
  input wire arf_pkg::arf_ahb_rsp_t ahb_out,
  input wire arf_pkg::arf_core_in_t core_in,
  input wire arf_pkg::arf_core_out_t core_out,
  input wire logic conv_trigger_in,
  input wire logic window_lt_out
);
  logic rd_q, wr_q, en_r, bm_r;
  logic [7:0] a_q, lth_r;
  wire take_w = ahb_in.hsel & ahb_in.htrans[1] & ahb_in.hready;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      a_q <= 8'h00;
    end else begin
      rd_q <= take_w & ~ahb_in.hwrite;
      wr_q <= take_w & ahb_in.hwrite;
      a_q <= ahb_in.haddr[7:0];
    end
  end
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      en_r <= 1'b0;
      bm_r <= 1'b0;
      lth_r <= ARF_LT_RST;
    end else if (wr_q && a_q == ARF_OFS_CTRL) begin
      en_r <= ahb_in.hwdata[ARF_CTRL_EN_BIT];
      bm_r <= ahb_in.hwdata[ARF_CTRL_BURST_BIT];
    end else if (wr_q && a_q == ARF_OFS_LT_HIGH) begin
      lth_r <= ahb_in.hwdata[7:0];
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  sequence s_quiet; !core_out.conv_start [*2]; endsequence
  property p_pulse; core_out.conv_start |=> !core_out.conv_start; endproperty
  a_pulse: assert property (p_pulse) else $error("start pulse too long");
  property p_start_pwr; core_out.conv_start |-> core_out.power_on; endproperty
  a_start_pwr: assert property (p_start_pwr) else $error("start without power");
  property p_pwrup; $rose(core_out.power_on) |-> s_quiet; endproperty
  a_pwrup: assert property (p_pwrup) else $error("start inside power-up wait");
  property p_en_pwr; en_r && $past(en_r) |-> core_out.power_on; endproperty
  a_en_pwr: assert property (p_en_pwr) else $error("always-on lost power");
  property p_off; !en_r && !bm_r && !$past(en_r) && !$past(bm_r) |-> !core_out.power_on; endproperty
  a_off: assert property (p_off) else $error("power with both enables clear");
  property p_res_zero;
    rd_q && (a_q == ARF_OFS_RES_HIGH || a_q == ARF_OFS_RES_LOW) |-> ahb_out.hrdata[31:8] == 24'h0;
  endproperty
  a_res_zero: assert property (p_res_zero) else $error("result upper bits set");
  property p_lt; rd_q && a_q == ARF_OFS_LT_HIGH |-> ahb_out.hrdata == {24'h0, $past(lth_r)}; endproperty
  a_lt: assert property (p_lt) else $error("threshold high byte wrong");
  property p_hold; !rd_q |-> $stable(ahb_out.hrdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without a read");
endmodule : arf_result_format_asserts

// file: tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import arf_pkg::*;
  logic clk_in, resetn_in, trig, wlt;
  arf_ahb_req_t ahb_in, m;
  arf_ahb_rsp_t ahb_out;
  arf_core_in_t core_in;
  arf_core_out_t core_out;
  logic [9:0] code;
  logic [3:0] lat;
  logic [31:0] q;
  logic [15:0] last;
  int mismatches, check_count, cyc, nst;
  arf_result_format #(.POWERUP_CYC(2)) dut (.clk_in(clk_in), .resetn_in(resetn_in), .ahb_in(ahb_in),
    .ahb_out(ahb_out), .core_in(core_in), .core_out(core_out), .conv_trigger_in(trig), .window_lt_out(wlt));
  arf_core_model core (.clk_in(clk_in), .core_in(core_out), .code_in(code), .lat_in(lat), .core_out(core_in));
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  always_comb begin
    ahb_in = m;
    ahb_in.hready = ahb_out.hreadyout;
  end
  always @(posedge clk_in) begin
    cyc++;
    if (core_out.conv_start === 1'b1) nst++;
    if (cyc > 40000) begin
      mismatches++;
      stop_test;
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h, expected %h", $time, g, e);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    m.hsel <= 1'b1;
    m.htrans <= 2'h2;
    m.hwrite <= w;
    m.haddr <= {24'h0, a};
    do @(posedge clk_in); while (ahb_in.hready !== 1'b1);
    m.hsel <= 1'b0;
    m.htrans <= 2'h0;
    m.hwdata <= d;
    do @(posedge clk_in); while (ahb_in.hready !== 1'b1);
    q = ahb_out.hrdata;
    chk({31'h0, ahb_out.hresp}, 32'h0);
  endtask : bus
  task automatic run(input logic [7:0] c, input logic [9:0] v, input logic p, input int s, input logic [15:0] e);
    int n0;
    code <= v;
    bus(1'b1, ARF_OFS_CTRL, {24'h0, c});
    n0 = nst;
    if (p) begin
      trig <= 1'b1;
      repeat (2) @(posedge clk_in);
      trig <= 1'b0;
    end else begin
      bus(1'b1, ARF_OFS_TRIGGER, 32'h1);
    end
    while (core_out.conv_start !== 1'b1) @(posedge clk_in);
    bus(1'b0, ARF_OFS_RES_HIGH, 32'h0);
    chk(q, {24'h0, last[15:8]});
    do bus(1'b0, ARF_OFS_STATUS, 32'h0); while (q[ARF_STAT_BUSY_BIT] !== 1'b0);
    chk(nst - n0, s);
    bus(1'b0, ARF_OFS_RES_HIGH, 32'h0);
    chk(q, {24'h0, e[15:8]});
    bus(1'b0, ARF_OFS_RES_LOW, 32'h0);
    chk(q, {24'h0, e[7:0]});
    chk({31'h0, wlt}, {31'h0, e < 16'h2000});
    last = e;
  endtask : run
  task automatic t_regs;
    bus(1'b0, ARF_OFS_LT_HIGH, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, ARF_OFS_CLK_DIV, 32'h0);
    chk(q, 32'h1f);
    bus(1'b1, ARF_OFS_LT_HIGH, 32'h20);
    bus(1'b0, ARF_OFS_LT_HIGH, 32'h0);
    chk(q, 32'h20);
    bus(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0);
    $display("registers test done");
  endtask : t_regs
  task automatic t_single;
    int n0;
    run(8'h01, 10'h3ff, 1'b0, 1, 16'h03ff);
    run(8'h11, 10'h3ff, 1'b0, 1, 16'hffc0);
    run(8'h11, 10'h100, 1'b1, 1, 16'h4000);
    bus(1'b1, ARF_OFS_CTRL, 32'h0);
    n0 = nst;
    bus(1'b1, ARF_OFS_TRIGGER, 32'h1);
    repeat (20) @(posedge clk_in);
    chk(nst - n0, 0);
    $display("single test done");
  endtask : t_single
  task automatic t_burst;
    for (int r = 1; r <= 5; r++) begin
      lat <= r[3:0];
      bus(1'b1, ARF_OFS_ACC_CFG, r);
      run(r[0] ? 8'h03 : 8'h02, 10'h3ff, r[1], 1 << (r + 1), 16'h3ff << (r + 1));
    end
    $display("burst test done");
  endtask : t_burst
  // Non-burst series: one sample per trigger, result only after the fourth
  task automatic t_multi;
    int n0;
    code <= 10'h100;
    bus(1'b1, ARF_OFS_ACC_CFG, 32'h1);
    bus(1'b1, ARF_OFS_CTRL, 32'h1);
    n0 = nst;
    for (int i = 0; i < 4; i++) begin
      if (i == 3) begin
        bus(1'b0, ARF_OFS_RES_HIGH, 32'h0);
        chk(q, {24'h0, last[15:8]});
      end
      bus(1'b1, ARF_OFS_TRIGGER, 32'h1);
      repeat (30) @(posedge clk_in);
    end
    chk(nst - n0, 4);
    bus(1'b0, ARF_OFS_RES_HIGH, 32'h0);
    chk(q, 32'h04);
    bus(1'b0, ARF_OFS_RES_LOW, 32'h0);
    chk(q, 32'h00);
    chk({31'h0, wlt}, 32'h1);
    last = 16'h0400;
    $display("series test done");
  endtask : t_multi
  task automatic t_div;
    time t0;
    for (int d = 1; d <= 5; d += 4) begin
      bus(1'b1, ARF_OFS_CLK_DIV, d);
      @(posedge core_out.conv_clk);
      @(posedge core_out.conv_clk);
      t0 = $time;
      @(posedge core_out.conv_clk);
      chk(32'(($time - t0) / 20), d + 1);
    end
    $display("divider test done");
  endtask : t_div
  task automatic stop_test;
    $display("checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  initial begin
    m = '0;
    m.hsize = 3'h2;
    trig = 1'b0;
    code = 10'h0;
    lat = 4'h1;
    last = 16'h0;
    resetn_in = 1'b0;
    repeat (6) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(posedge clk_in);
    t_regs;
    t_single;
    t_burst;
    t_multi;
    t_div;
    stop_test;
  end
endmodule : tb_top
bind arf_result_format arf_result_format_asserts u_chk (.clk_in(clk_in), .resetn_in(resetn_in), .ahb_in(ahb_in),
  .ahb_out(ahb_out), .core_in(core_in), .core_out(core_out), .conv_trigger_in(conv_trigger_in),
  .window_lt_out(window_lt_out));
